// ### rtl/srstc_pkg.sv
package srstc_pkg;
	// Register word byte offsets
	localparam logic [7:0] OFS_ID_A      = 8'h00;
	localparam logic [7:0] OFS_ID_B      = 8'h04;
	localparam logic [7:0] OFS_CAP0      = 8'h08;
	localparam logic [7:0] OFS_CAP1      = 8'h0c;
	localparam logic [7:0] OFS_CAP2      = 8'h10;
	localparam logic [7:0] OFS_CAP3      = 8'h14;
	localparam logic [7:0] OFS_CAP4      = 8'h18;
	localparam logic [7:0] OFS_CAUSE     = 8'h1c;
	localparam logic [7:0] OFS_BO_CTRL   = 8'h20;
	localparam logic [7:0] OFS_SRST0     = 8'h24;
	localparam logic [7:0] OFS_SRST1     = 8'h28;
	localparam logic [7:0] OFS_SRST2     = 8'h2c;
	localparam logic [7:0] OFS_SYSREQ    = 8'h30;
	localparam logic [7:0] OFS_REG_CTRL  = 8'h34;
	// Cause bit positions
	localparam int CB_PIN  = 0;
	localparam int CB_POR  = 1;
	localparam int CB_BO   = 2;
	localparam int CB_SW   = 3;
	localparam int CB_WDT  = 4;
	localparam int CB_REG  = 5;
	localparam int NCAUSE  = 6;
	// Brown-out control fields
	localparam int BOC_RST = 0;
	localparam int BOC_FLT = 1;
	localparam int BOC_TIM = 2;
	localparam int BOC_TIMW = 14;
	localparam logic [31:0] BOC_RESET = 32'h0000_0000;
	localparam int SYSREQ_BIT = 0;
	localparam int REGC_EN = 0;
	// Timing
	localparam int CLK_MHZ      = 250;
	localparam int SETTLE_MS    = 15;
	localparam int BO_CLR_US    = 500;
	localparam int SETTLE_CYC   = SETTLE_MS * 1000 * CLK_MHZ;
	localparam int BO_CLR_CYC   = BO_CLR_US * CLK_MHZ;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// ### rtl/srstc_top.sv
// Chosen here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Behaviour
// - Six reset origins are accepted
// - Cause bits recorded and sticky across resets
// - Pin reset clears all other causes
// - Pin/power-on timed by main oscillator
// - Pin reset spares test port controller
// - Reset held during oscillator settle count
// - Release lets core fetch stack, PC, run
// - Power-up waits pin and detector inactive
// - Power-on detector active at first power-up
// - Power-on also resets test port controller
// - Brown-out reset disabled until software enables
// - Brown-out resets only when enable set
// - Filter (interrupt mode only) resamples after delay, else ignore
// - Confirmed brown-out raises interrupt only; reset is unfiltered
// - Brown-out condition cleared after 500 us
// - Per-peripheral soft reset on set-then-clear
// - Soft reset bits match clock gate layout
// - Soft reset hits all peripheral clock domains
// - System request resets whole system, boots
// - Seven read-only identification registers
// - Second watchdog time-out resets system
// - Regulator fault reset enabled by software
module srstc_top
	import srstc_pkg::*;
#(
	parameter int          SETTLE_CYCLES = SETTLE_CYC,
	parameter int          BO_CLEAR_CYCLES = BO_CLR_CYC,
	parameter int          NPERIPH = 32,
	parameter logic [31:0] ID_A = 32'h0001_0000, // Arbitrary value
	parameter logic [31:0] ID_B = 32'h0000_0001, // Arbitrary value
	parameter logic [31:0] CAP0 = 32'h0000_0000,
	parameter logic [31:0] CAP1 = 32'h0000_0000,
	parameter logic [31:0] CAP2 = 32'h0000_0000,
	parameter logic [31:0] CAP3 = 32'h0000_0000,
	parameter logic [31:0] CAP4 = 32'h0000_0000
)(
	input  wire logic               CORE_CLK_I,
	input  wire logic               RST_I,
	input  wire logic               CE_I,
	input  wire logic [7:0]         AVS_ADDRESS_I,
	input  wire logic               AVS_READ_I,
	input  wire logic               AVS_WRITE_I,
	input  wire logic [31:0]        AVS_WRITEDATA_I,
	input  wire logic [3:0]         AVS_BYTEENABLE_I,
	output logic [31:0]             AVS_READDATA_O,
	output logic                    AVS_WAITREQUEST_O,
	input  wire logic               RESET_PIN_N_I,
	input  wire logic               POR_DETECT_I,
	input  wire logic               BROWNOUT_DETECT_I,
	input  wire logic               WDT_SECOND_TIMEOUT_I,
	input  wire logic               WDT_RESET_EN_I,
	input  wire logic               REGULATOR_FAULT_I,
	output logic                    CORE_RESET_O,
	output logic                    TAP_RESET_O,
	output logic                    MOSC_TIMING_O,
	output logic                    BROWNOUT_IRQ_O,
	output logic [NPERIPH-1:0]      PERIPH_RESET_O [3]
);

	typedef enum logic [1:0]
	{
		ST_RUN    = 2'b00,
		ST_HOLD   = 2'b01,
		ST_SETTLE = 2'b10
	} srstc_state_t;

	typedef enum logic [1:0]
	{
		BO_IDLE   = 2'b00,
		BO_WAIT   = 2'b01,
		BO_COOL   = 2'b10
	} srstc_bo_t;

	srstc_state_t          state;
	srstc_bo_t             bo_state;
	logic [31:0]           settle_cnt;
	logic [31:0]           bo_cnt;
	logic [NCAUSE-1:0]     cause;
	logic [31:0]           bo_ctrl;
	logic                  reg_rst_en;
	logic [NPERIPH-1:0]    srst [3];
	logic [NPERIPH-1:0]    srst_fire [3];
	logic                  sys_req;
	logic                  por_seen;
	logic                  ack;
	logic                  bo_fire;
	logic                  pin_act;
	logic                  por_act;
	logic                  wdt_req;
	logic                  reg_req;
	logic                  int_req;
	logic                  wr;
	logic [NCAUSE-1:0]     next_cause;
	logic [31:0]           rdata;

	assign pin_act = !RESET_PIN_N_I;
	assign por_act = POR_DETECT_I && !por_seen;
	assign wdt_req = WDT_SECOND_TIMEOUT_I && WDT_RESET_EN_I;
	assign reg_req = REGULATOR_FAULT_I && reg_rst_en;
	assign int_req = bo_fire || sys_req || wdt_req || reg_req;
	// Write lands at the edge where waitrequest is sampled low
	assign wr = AVS_WRITE_I && ack;

	// Detector honoured until it first goes low, ignored ever after
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			por_seen <= 1'b0;
		else if (CE_I && !POR_DETECT_I)
			por_seen <= 1'b1;
	end

	// Reset sequencer: hold while pin or power-on source is active, then settle count
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			state <= ST_HOLD;
			settle_cnt <= '0;
		end
		else if (CE_I)
		begin
			unique case (state)
				ST_RUN:
					if (pin_act || por_act || int_req)
						state <= ST_HOLD;
				ST_HOLD:
					if (!pin_act && !por_act)
					begin
						state <= ST_SETTLE;
						settle_cnt <= '0;
					end
				ST_SETTLE:
					if (pin_act || por_act)
						state <= ST_HOLD;
					else if (settle_cnt == 32'(SETTLE_CYCLES - 1))
						state <= ST_RUN;
					else
						settle_cnt <= settle_cnt + 32'd1;
				default:
					state <= ST_HOLD;
			endcase
		end
	end

	assign CORE_RESET_O = (state != ST_RUN);
	// Main oscillator times settle; internal oscillator otherwise
	assign MOSC_TIMING_O = (state == ST_SETTLE);
	assign TAP_RESET_O = por_act;

	// Brown-out filter and cool-down
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			bo_state <= BO_IDLE;
			bo_cnt <= '0;
			bo_fire <= 1'b0;
			BROWNOUT_IRQ_O <= 1'b0;
		end
		else if (CE_I)
		begin
			bo_fire <= 1'b0;
			BROWNOUT_IRQ_O <= 1'b0;
			unique case (bo_state)
				BO_IDLE:
					if (BROWNOUT_DETECT_I)
					begin
						bo_cnt <= '0;
						if (bo_ctrl[BOC_FLT] && !bo_ctrl[BOC_RST])
							bo_state <= BO_WAIT;
						else
						begin
							bo_fire <= bo_ctrl[BOC_RST];
							BROWNOUT_IRQ_O <= !bo_ctrl[BOC_RST];
							bo_state <= BO_COOL;
						end
					end
				BO_WAIT:
					if (bo_cnt >= 32'(bo_ctrl[BOC_TIM +: BOC_TIMW]))
					begin
						bo_cnt <= '0;
						BROWNOUT_IRQ_O <= BROWNOUT_DETECT_I;
						bo_state <= BROWNOUT_DETECT_I ? BO_COOL : BO_IDLE;
					end
					else
						bo_cnt <= bo_cnt + 32'd1;
				BO_COOL:
					if (bo_cnt == 32'(BO_CLEAR_CYCLES - 1))
						bo_state <= BO_IDLE;
					else
						bo_cnt <= bo_cnt + 32'd1;
				default:
					bo_state <= BO_IDLE;
			endcase
		end
	end

	// Cause recording: hardware set wins over software clear
	always_comb
	begin
		next_cause = cause;
		if (wr && AVS_ADDRESS_I == OFS_CAUSE && AVS_BYTEENABLE_I[0])
			next_cause = cause & ~AVS_WRITEDATA_I[NCAUSE-1:0];
		if (state == ST_RUN)
		begin
			if (bo_fire)
				next_cause[CB_BO] = 1'b1;
			if (sys_req)
				next_cause[CB_SW] = 1'b1;
			if (wdt_req)
				next_cause[CB_WDT] = 1'b1;
			if (reg_req)
				next_cause[CB_REG] = 1'b1;
		end
		if (por_act)
			next_cause[CB_POR] = 1'b1;
		if (pin_act && !por_act)
			next_cause = NCAUSE'(1) << CB_PIN;
	end

	// Cause bits survive the block's own reset sequences, save a pin reset, which leaves only the pin bit
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			cause <= '0;
		else if (CE_I)
			cause <= next_cause;
	end

	// Software registers
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I || (CE_I && CORE_RESET_O && state != ST_SETTLE))
		begin
			bo_ctrl <= BOC_RESET;
			reg_rst_en <= 1'b0;
			sys_req <= 1'b0;
			for (int i = 0; i < 3; i++)
				srst[i] <= '0;
		end
		else if (CE_I)
		begin
			sys_req <= 1'b0;
			if (wr && AVS_BYTEENABLE_I[0])
			begin
				unique case (AVS_ADDRESS_I)
					OFS_BO_CTRL:  bo_ctrl <= AVS_WRITEDATA_I;
					OFS_REG_CTRL: reg_rst_en <= AVS_WRITEDATA_I[REGC_EN];
					OFS_SYSREQ:   sys_req <= AVS_WRITEDATA_I[SYSREQ_BIT];
					OFS_SRST0:    srst[0] <= AVS_WRITEDATA_I[NPERIPH-1:0];
					OFS_SRST1:    srst[1] <= AVS_WRITEDATA_I[NPERIPH-1:0];
					OFS_SRST2:    srst[2] <= AVS_WRITEDATA_I[NPERIPH-1:0];
					default:      ;
				endcase
			end
		end
	end

	// Peripheral reset pulse on clear of a set bit, all clock domains
	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			for (int i = 0; i < 3; i++)
				srst_fire[i] <= '0;
		end
		else if (CE_I)
		begin
			for (int i = 0; i < 3; i++)
				srst_fire[i] <= srst[i] & ~(wr && AVS_BYTEENABLE_I[0]
					&& AVS_ADDRESS_I == (OFS_SRST0 + 8'(4 * i))
					? AVS_WRITEDATA_I[NPERIPH-1:0] : srst[i]);
		end
	end

	// Soft bits hold the peripheral in reset while set; bit layout equals clock gates
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			PERIPH_RESET_O[i] = srst[i] | srst_fire[i] | {NPERIPH{CORE_RESET_O}};
	end

	// Avalon slave: one wait cycle then answer
	always_comb
	begin
		unique case (AVS_ADDRESS_I)
			OFS_ID_A:     rdata = ID_A;
			OFS_ID_B:     rdata = ID_B;
			OFS_CAP0:     rdata = CAP0;
			OFS_CAP1:     rdata = CAP1;
			OFS_CAP2:     rdata = CAP2;
			OFS_CAP3:     rdata = CAP3;
			OFS_CAP4:     rdata = CAP4;
			OFS_CAUSE:    rdata = {{(32-NCAUSE){1'b0}}, cause};
			OFS_BO_CTRL:  rdata = bo_ctrl;
			OFS_SRST0:    rdata = 32'(srst[0]);
			OFS_SRST1:    rdata = 32'(srst[1]);
			OFS_SRST2:    rdata = 32'(srst[2]);
			OFS_REG_CTRL: rdata = {31'h0, reg_rst_en};
			default:      rdata = UNMAPPED_DATA;
		endcase
	end

	always_ff @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			ack <= 1'b0;
			AVS_READDATA_O <= '0;
		end
		else if (CE_I)
		begin
			ack <= (AVS_READ_I || AVS_WRITE_I) && !ack;
			if (AVS_READ_I && !ack)
				AVS_READDATA_O <= rdata;
		end
	end

	// Frozen clock enable keeps the master waiting
	assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && (!ack || !CE_I);

	sequence s_settle_done;
		CE_I && state == ST_SETTLE && settle_cnt == 32'(SETTLE_CYCLES - 1)
		&& !pin_act && !por_act;
	endsequence
	sequence s_bo_resample;
		CE_I && bo_state == BO_WAIT && bo_cnt >= 32'(bo_ctrl[BOC_TIM +: BOC_TIMW]);
	endsequence

	a_pin_cause_only: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && pin_act && !por_act |=> cause == 6'h01)
		else $error("pin reset left other cause bits");
	a_release_after_settle: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		$fell(CORE_RESET_O) |-> $past(state) == ST_SETTLE)
		else $error("reset released without settle");
	a_wdt_reset_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && wdt_req && state == ST_RUN |=> CORE_RESET_O && cause[CB_WDT])
		else $error("watchdog reset missed");
	a_bo_disabled: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		!bo_ctrl[BOC_RST] |=> !bo_fire)
		else $error("brown-out reset while disabled");
	a_sysreq_reset: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && sys_req && state == ST_RUN |=> CORE_RESET_O)
		else $error("system request ignored");
	a_tap_spared: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		pin_act && !por_act |-> !TAP_RESET_O)
		else $error("pin reset hit test port");
	a_reg_disabled: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && REGULATOR_FAULT_I && !reg_rst_en && !pin_act && !por_act |=> !cause[CB_REG] || $past(cause[CB_REG]))
		else $error("regulator reset while disabled");
	a_periph_reset: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && wr && AVS_BYTEENABLE_I[0] && AVS_ADDRESS_I == OFS_SRST1
		&& |(srst[1] & ~AVS_WRITEDATA_I[NPERIPH-1:0]) |=> PERIPH_RESET_O[1] != '0)
		else $error("peripheral soft reset not driven");
	a_boot_after_settle: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		s_settle_done |=> !CORE_RESET_O)
		else $error("reset not released after settle");
	a_bo_resample_drop: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		s_bo_resample ##0 !BROWNOUT_DETECT_I |=> bo_state == BO_IDLE && !BROWNOUT_IRQ_O)
		else $error("filtered brown-out acted on");
	a_bo_resample_hit: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		s_bo_resample ##0 BROWNOUT_DETECT_I |=> BROWNOUT_IRQ_O && bo_state == BO_COOL)
		else $error("confirmed brown-out ignored");
	a_bo_cool_quiet: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && bo_state == BO_COOL |=> !bo_fire)
		else $error("brown-out retriggered during cool-down");
	a_hold_while_active: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && state == ST_HOLD && (pin_act || por_act) |=> state == ST_HOLD)
		else $error("settle started while reset source active");
	a_ctrl_cleared: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
		CE_I && CORE_RESET_O && state != ST_SETTLE |=> bo_ctrl == BOC_RESET && !reg_rst_en)
		else $error("control enables survived reset");

endmodule

// ### bench/srstc_ext_model.sv
`timescale 1ns/1ns
module srstc_ext_model
#(
	parameter int POR_CYC  = 6,
	parameter int HOLD_CYC = 4
)(
	input  wire logic clk_i,
	input  wire logic pin_req_i,
	input  wire logic bo_req_i,
	output logic      pin_n_o,
	output logic      por_o,
	output logic      bo_o
);
	int por_cnt = 0;
	int pin_cnt = 0;
	int bo_cnt  = 0;
	// Detector fires once from time zero, never again
	always_ff @(posedge clk_i)
	begin
		if (por_cnt < POR_CYC)
			por_cnt <= por_cnt + 1;
	end
	// Pin and supply dip held a few cycles, like a real glitch
	always_ff @(posedge clk_i)
	begin
		pin_cnt <= pin_req_i ? HOLD_CYC : (pin_cnt > 0 ? pin_cnt - 1 : 0);
		bo_cnt  <= bo_req_i ? HOLD_CYC : (bo_cnt > 0 ? bo_cnt - 1 : 0);
	end
	assign por_o   = por_cnt < POR_CYC;
	assign pin_n_o = pin_cnt == 0;
	assign bo_o    = bo_cnt != 0;
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	import srstc_pkg::*;
	localparam int SC = 16;
	localparam int BC = 8;
	logic        clk = 1'b0;
	logic        ce = 1'b1;
	logic [3:0]  be = 4'hf;
	logic        ovl = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  adr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wd = 32'h0;
	logic        wdt = 1'b0;
	logic        wdt_en = 1'b0;
	logic        reg_f = 1'b0;
	logic        pin_req = 1'b0;
	logic        bo_req = 1'b0;
	logic [31:0] rdata, q;
	logic        waitreq, core_rst, tap_rst, mosc, bo_irq, pin_n, por, bo, tap_seen;
	logic [31:0] prst [3];
	int          n_fail = 0;
	int          comparisons = 0;
	int          st;
	always #2 clk = ~clk;
	srstc_ext_model ext (.clk_i(clk), .pin_req_i(pin_req), .bo_req_i(bo_req),
		.pin_n_o(pin_n), .por_o(por), .bo_o(bo));
	srstc_top #(.SETTLE_CYCLES(SC), .BO_CLEAR_CYCLES(BC), .CAP0(32'h11), .CAP1(32'h22),
		.CAP2(32'h33), .CAP3(32'h44), .CAP4(32'h55)) uut (
		.CORE_CLK_I(clk), .RST_I(rst), .CE_I(ce), .AVS_ADDRESS_I(adr),
		.AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd),
		.AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
		.RESET_PIN_N_I(pin_n), .POR_DETECT_I(por), .BROWNOUT_DETECT_I(bo),
		.WDT_SECOND_TIMEOUT_I(wdt), .WDT_RESET_EN_I(wdt_en),
		.REGULATOR_FAULT_I(reg_f), .CORE_RESET_O(core_rst), .TAP_RESET_O(tap_rst),
		.MOSC_TIMING_O(mosc), .BROWNOUT_IRQ_O(bo_irq), .PERIPH_RESET_O(prst));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= ~w;
		wd <= d;
		do
		begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		chk({31'h0, waitreq}, 32'h0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask
	task automatic pulse(input int k);
		@(posedge clk);
		case (k)
			0: pin_req <= 1'b1;
			1: bo_req <= 1'b1;
			2: wdt <= 1'b1;
			default: reg_f <= 1'b1;
		endcase
		@(posedge clk);
		{pin_req, bo_req, wdt, reg_f} <= 4'h0;
	endtask
	// Settle cycles counted so a short hold shows up
	task automatic rst_cyc(input logic exp);
		int n;
		n = 0;
		st = 0;
		do
		begin
			@(negedge clk);
			n++;
			tap_seen |= tap_rst;
		end while (core_rst !== 1'b1 && n < 12);
		chk({31'h0, core_rst}, {31'h0, exp});
		n = 0;
		while (core_rst !== 1'b0 && n < 200)
		begin
			@(negedge clk);
			n++;
			tap_seen |= tap_rst;
			st += (mosc === 1'b1);
			ovl |= (mosc === 1'b1) && (por === 1'b1 || pin_n === 1'b0);
		end
		chk({31'h0, core_rst}, 32'h0);
	endtask
	task automatic t_ids;
		logic [31:0] idv [7];
		idv = '{32'h0001_0000, 32'h1, 32'h11, 32'h22, 32'h33, 32'h44, 32'h55};
		for (int i = 0; i < 7; i++)
			rdc(8'(4 * i), idv[i]);
		bus(1'b1, OFS_ID_A, 32'hffff_ffff);
		rdc(OFS_ID_A, idv[0]);
		rdc(8'h3c, UNMAPPED_DATA);
		be <= 4'he;
		bus(1'b1, OFS_REG_CTRL, 32'h1);
		be <= 4'hf;
		rdc(OFS_REG_CTRL, 32'h0);
	endtask
	task automatic t_bo_flt(input logic [31:0] ctl, input logic exp);
		logic seen;
		seen = 1'b0;
		bus(1'b1, OFS_BO_CTRL, ctl);
		pulse(1);
		repeat (14)
		begin
			@(negedge clk);
			seen |= bo_irq;
		end
		chk({31'h0, seen}, {31'h0, exp});
		chk({31'h0, core_rst}, 32'h0);
	endtask
	// A frozen clock enable must swallow a short pin pulse
	task automatic t_ce;
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		ce <= 1'b0;
		pulse(0);
		repeat (8)
		begin
			@(negedge clk);
			seen |= core_rst;
		end
		@(posedge clk);
		ce <= 1'b1;
		chk({31'h0, seen}, 32'h0);
		rdc(OFS_CAUSE, 32'h3c);
	endtask
	task automatic t_bo_off;
		int n;
		logic seen;
		seen = 1'b0;
		rdc(OFS_BO_CTRL, BOC_RESET);
		pulse(1);
		for (n = 0; n < 10; n++)
		begin
			@(negedge clk);
			seen |= bo_irq;
		end
		chk({31'h0, seen}, 32'h1);
		rst_cyc(1'b0);
	endtask
	task automatic t_int(input int k, input logic [7:0] en_ofs, input int cb, input logic [31:0] exp);
		for (int e = 0; e < 2; e++)
		begin
			if (e == 1)
				bus(1'b1, en_ofs, 32'h1);
			pulse(k);
			rst_cyc(e[0]);
		end
		rdc(OFS_CAUSE, exp | (32'h1 << cb));
		rdc(en_ofs, 32'h0);
	endtask
	task automatic t_pin;
		tap_seen = 1'b0;
		pulse(0);
		rst_cyc(1'b1);
		chk({31'h0, tap_seen}, 32'h0);
		chk({31'h0, st >= SC}, 32'h1);
		chk({31'h0, ovl}, 32'h0);
		rdc(OFS_CAUSE, 32'h1 << CB_PIN);
	endtask
	task automatic t_periph;
		bus(1'b1, OFS_SRST1, 32'h20);
		@(negedge clk);
		chk(prst[1], 32'h20);
		chk(prst[0] | prst[2], 32'h0);
		bus(1'b1, OFS_SRST1, 32'h0);
		@(negedge clk);
		chk(prst[1], 32'h20);
		repeat (2) @(negedge clk);
		chk(prst[1], 32'h0);
		chk({31'h0, core_rst}, 32'h0);
	endtask
	task stop_test;
		$display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
		if (n_fail == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#200000;
		n_fail++;
		stop_test;
	end
	initial
	begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk({31'h0, tap_rst}, 32'h1);
		rst_cyc(1'b1);
		chk({31'h0, st >= SC}, 32'h1);
		chk({31'h0, ovl}, 32'h0);
		rdc(OFS_CAUSE, 32'h1 << CB_POR);
		bus(1'b1, OFS_CAUSE, 32'h3f);
		rdc(OFS_CAUSE, 32'h0);
		t_ids;
		t_bo_off;
		t_bo_flt(32'h6, 1'b1);
		t_bo_flt(32'he, 1'b0);
		t_int(1, OFS_BO_CTRL, CB_BO, 32'h0);
		bus(1'b1, OFS_SYSREQ, 32'h1);
		rst_cyc(1'b1);
		rdc(OFS_CAUSE, 32'h1 << CB_BO | 32'h1 << CB_SW);
		wdt_en <= 1'b0;
		t_int(3, OFS_REG_CTRL, CB_REG, 32'h1 << CB_BO | 32'h1 << CB_SW);
		pulse(2);
		rst_cyc(1'b0);
		wdt_en <= 1'b1;
		pulse(2);
		rst_cyc(1'b1);
		rdc(OFS_CAUSE, 32'h3c);
		t_ce;
		t_pin;
		t_periph;
		stop_test;
	end
endmodule
